// file: dv/ppk_asserts.sv
// port-level assertions for the peak picker, bound to its top module
`timescale 1ns/1ps
module ppk_asserts
  import ppk_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic [1:0]    mode_sel,
  input wire logic          unit_fahrenheit,
  input wire logic [TW-1:0] subrange_lo,
  input wire logic [TW-1:0] subrange_hi,
  input wire logic [CW-1:0] clear_interval,
  input wire logic [RW-1:0] decay_rate,
  input wire logic [DW-1:0] start_delay,
  input wire logic [TW-1:0] reset_below_threshold,
  input wire logic          sample_valid,
  input wire logic          sample_ready,
  input wire logic [TW-1:0] sample_temp,
  input wire logic          out_valid,
  input wire logic          out_ready,
  input wire logic [TW-1:0] out_temp,
  input wire logic [TW-1:0] held_peak,
  input wire logic          hold_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_take_empty;
    sample_valid && sample_ready && !out_valid;
  endsequence
  // smart settings latch one cycle late, so they must have been steady
  sequence s_smart_steady;
    !$past(rst) && mode_sel == 2'h3 && $stable(mode_sel) && $stable(reset_below_threshold) && $stable(subrange_hi);
  endsequence
  property p_reset_clear;
    $fell(rst) |-> !out_valid && held_peak == '0 && !hold_active;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
  property p_off_pass;
    s_take_empty ##0 (mode_sel == 2'h0) |=> out_temp == $past(sample_temp);
  endproperty
  a_off_pass: assert property (p_off_pass) else $error("off mode altered a sample");
  property p_off_nohold;
    (mode_sel == 2'h0) [*3] |-> !hold_active;
  endproperty
  a_off_nohold: assert property (p_off_nohold) else $error("hold shown in off mode");
  property p_answer;
    s_take_empty |=> out_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("taken sample not answered");
  property p_stand;
    out_valid && !out_ready |=> out_valid && $stable(out_temp);
  endproperty
  a_stand: assert property (p_stand) else $error("output word dropped or changed");
  property p_below;
    s_smart_steady ##0 s_take_empty ##0 (sample_temp <= reset_below_threshold && reset_below_threshold <= subrange_hi)
      |=> out_temp == $past(sample_temp);
  endproperty
  a_below: assert property (p_below) else $error("held value shown below threshold");
  property p_smart_ge;
    s_take_empty ##0 (mode_sel == 2'h3) |=> out_temp >= $past(sample_temp);
  endproperty
  a_smart_ge: assert property (p_smart_ge) else $error("smart output below momentary");
  property p_decay_step;
    (hold_active && mode_sel == 2'h3 && $stable(mode_sel)) [*2] |-> {1'b0, held_peak} + 19'h0_0001 >= {1'b0, $past(held_peak)};
  endproperty
  a_decay_step: assert property (p_decay_step) else $error("peak fell too fast");
  property p_no_decay;
    (hold_active && mode_sel == 2'h3 && $stable(mode_sel) && decay_rate == '0) [*4] |-> held_peak >= $past(held_peak);
  endproperty
  a_no_decay: assert property (p_no_decay) else $error("peak fell at zero rate");
endmodule

bind ppk_peak_picker ppk_asserts #(.TICK(TICK)) u_chk (.*);

// file: dv/ppk_sink.sv
// output stage model: accepts words with a steady, throttled or stalled ready
`timescale 1ns/1ps
module ppk_sink (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic slow,
  output logic      out_ready
);
  logic [1:0] cnt_q;

  // throttling lets words stand in the fifo across several edges
  always_ff @(posedge mclk) begin
    cnt_q     <= rst ? 2'h0 : cnt_q + 2'h1;
    out_ready <= !rst && !stall && (!slow || cnt_q == 2'h0);
  end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the peak picker
`timescale 1ns/1ps
module tb_top;
  import ppk_pkg::*;
  localparam logic [TW-1:0] SKIP = 18'h3_FFFF;  // word not compared
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic          unit_f = 1'b0;
  logic          s_valid = 1'b0;
  logic          stall = 1'b1;
  logic          slow = 1'b0;
  logic [1:0]    mode = 2'h0;
  logic [TW-1:0] thr = 18'h0_0000;
  logic [TW-1:0] s_temp = 18'h0_0000;
  logic [CW-1:0] clr = 15'h0000;
  logic [RW-1:0] rate = 15'h0000;
  logic [DW-1:0] dly = 10'h000;
  logic [TW-1:0] last, o_temp, peak, e;
  logic          s_ready, o_valid, o_ready, hold;
  logic [TW-1:0] exp_q[$];
  int            n_errors = 0, checked = 0, seed = 3, cyc = 0, n900 = 0, r, lim, d;

  // 1 ms is 100 cycles with this tick
  ppk_peak_picker #(.TICK(10)) dut (
    .mclk(mclk), .rst(rst), .mode_sel(mode), .unit_fahrenheit(unit_f),
    .subrange_lo(18'h0_0064), .subrange_hi(18'h0_2710), .clear_interval(clr),
    .decay_rate(rate), .start_delay(dly), .reset_below_threshold(thr),
    .sample_valid(s_valid), .sample_ready(s_ready), .sample_temp(s_temp),
    .out_valid(o_valid), .out_ready(o_ready), .out_temp(o_temp),
    .held_peak(peak), .hold_active(hold));
  ppk_sink u_sink (.mclk(mclk), .rst(rst), .stall(stall), .slow(slow), .out_ready(o_ready));

  always #5 mclk = ~mclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [TW-1:0] seen, input logic [TW-1:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // valid stays up on return, so the caller follows with send or idle
  task automatic send(input logic [TW-1:0] t, input logic [TW-1:0] w);
    s_valid <= 1'b1;
    s_temp  <= t;
    #1;
    while (s_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    exp_q.push_back(w);
  endtask

  task automatic idle(input int n);
    s_valid <= 1'b0;
    repeat (n) @(posedge mclk);
    while (exp_q.size() != 0) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
    if (o_valid === 1'b1 && o_ready === 1'b1 && rst === 1'b0) begin
      last = o_temp;
      n900 += int'(o_temp === 18'h0_0384);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~o_temp;
      if (e !== SKIP) check(o_temp, e);
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      send(r[TW-1:0], r[TW-1:0]);
    end
    #1;
    check(TW'(s_ready), 18'h0_0000);
    @(posedge mclk);
    stall <= 1'b0;
    slow  <= 1'b1;
    idle(1);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      send(r[TW-1:0], r[TW-1:0]);
    end
    slow <= 1'b0;
    idle(1);
    $display("off mode and fifo test done");
    // threshold below the sub-range is raised to its low end
    mode <= 2'h3;
    thr  <= 18'h0_0032;
    idle(4);
    send(18'h0_01F4, 18'h0_01F4);
    send(18'h0_0320, 18'h0_0320);
    send(18'h0_0258, 18'h0_0320);
    send(18'h0_0050, 18'h0_0050);
    send(18'h0_01F4, 18'h0_01F4);
    send(18'h0_0064, 18'h0_0064);
    idle(1);
    $display("smart hold test done");
    dly <= 10'h002;
    thr <= 18'h0_00C8;
    idle(4);
    send(18'h0_0258, 18'h0_0258);
    send(18'h0_0384, 18'h0_0384);
    send(18'h0_012C, 18'h0_012C);
    idle(2300);
    check(TW'(hold), 18'h0_0001);
    check(peak, 18'h0_012C);
    send(18'h0_028A, 18'h0_028A);
    send(18'h0_01F4, 18'h0_028A);
    // empty fifo here so the below-threshold assertion sees this take
    idle(1);
    send(18'h0_0096, 18'h0_0096);
    send(18'h0_00C8, 18'h0_00C8);
    idle(1);
    $display("start delay test done");
    for (int u = 0; u < 2; u++) begin
      mode <= 2'h0;
      idle(2);
      mode   <= 2'h3;
      unit_f <= u[0];
      rate   <= 15'h7530;
      dly    <= 10'h000;
      idle(4);
      send(18'h0_03E8, 18'h0_03E8);
      send(18'h0_012C, SKIP);
      idle(1000);
      send(18'h0_012C, SKIP);
      idle(1);
      // tenth-degree steps lost in 10 ms at the clamped rate
      lim = int'(u ? DECAY_MAX_F : DECAY_MAX_C) / 1000;
      d   = int'(18'h0_03E8) - int'(last);
      check(TW'(d >= lim - 1 && d <= lim + 1), 18'h0_0001);
      $display("decay test done");
    end
    // auto mode: max per hot object, a new object restarts it
    mode <= 2'h1;
    idle(2);
    send(18'h0_01F4, 18'h0_01F4);
    send(18'h0_0320, 18'h0_0320);
    send(18'h0_0258, 18'h0_0320);
    send(18'h0_0032, 18'h0_0320);
    send(18'h0_012C, 18'h0_012C);
    send(18'h0_0190, 18'h0_0190);
    send(18'h0_015E, 18'h0_0190);
    idle(1);
    check(peak, 18'h0_0190);
    check(TW'(hold), 18'h0_0001);
    $display("auto mode test done");
    // 3 ms is raised to the 10 ms minimum interval
    mode <= 2'h2;
    clr  <= 15'h0003;
    idle(2);
    n900 = 0;
    send(18'h0_0384, SKIP);
    for (int i = 0; i < 40; i++) begin
      idle(99);
      send(18'h0_0064, SKIP);
    end
    idle(1);
    check(TW'(n900 >= 10 && n900 <= 12), 18'h0_0001);
    check(last, 18'h0_0064);
    $display("clear time test done");
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    check(peak, 18'h0_0000);
    check(TW'(hold), 18'h0_0000);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule

// file: verilog/ppk_fifo.sv
// small fifo holding processed temperature words
`timescale 1ns/1ps
module ppk_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);
  localparam logic [PW:0] FULL = (PW+1)'(D);

  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: verilog/ppk_peak_picker.sv
// peak picker: off, auto, clear-time and smart peak hold on a sample stream
`timescale 1ns/1ps
module ppk_peak_picker
  import ppk_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [1:0]    mode_sel,
  input  wire logic          unit_fahrenheit,
  input  wire logic [TW-1:0] subrange_lo,
  input  wire logic [TW-1:0] subrange_hi,
  input  wire logic [CW-1:0] clear_interval,
  input  wire logic [RW-1:0] decay_rate,
  input  wire logic [DW-1:0] start_delay,
  input  wire logic [TW-1:0] reset_below_threshold,
  input  wire logic          sample_valid,
  output logic               sample_ready,
  input  wire logic [TW-1:0] sample_temp,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [TW-1:0]      out_temp,
  output logic [TW-1:0]      held_peak,
  output logic               hold_active
);
  // ------------------------------------------------------------
  // timebase and mode tracking
  // ------------------------------------------------------------
  logic      tick_fast;
  logic      tick_ms;
  ppk_mode_t mode_q;
  logic      mode_chg;
  logic      clr;
  logic      take;
  logic      fifo_ready;

  ppk_timebase #(
    .TICK(TICK)
  ) u_tb (
    .mclk      (mclk),
    .rst       (rst),
    .tick_fast (tick_fast),
    .tick_ms   (tick_ms)
  );

  assign mode_chg     = ppk_mode_t'(mode_sel) != mode_q;
  assign clr          = rst | mode_chg;
  assign sample_ready = fifo_ready;
  assign take         = sample_valid & fifo_ready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= PPK_MODE_OFF;
    end else begin
      mode_q <= ppk_mode_t'(mode_sel);
    end
  end

  // ------------------------------------------------------------
  // settings, clamped into their legal ranges
  // ------------------------------------------------------------
  logic [CW-1:0] clr_len;
  logic [RW-1:0] dec_max;
  logic [RW-1:0] dec_q;
  logic [DW-1:0] dly_q;
  logic [TW-1:0] thr_q;

  always_comb begin
    clr_len = clear_interval;
    if (clear_interval < CLR_MIN_MS) begin
      clr_len = CLR_MIN_MS;
    end else if (clear_interval > CLR_MAX_MS) begin
      clr_len = CLR_MAX_MS;
    end
  end

  assign dec_max = unit_fahrenheit ? DECAY_MAX_F : DECAY_MAX_C;

  // smart settings only follow the inputs while smart mode is selected
  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_q <= '0;
      dly_q <= '0;
      thr_q <= '0;
    end else if (mode_sel == PPK_MODE_SMART) begin
      dec_q <= (decay_rate > dec_max) ? dec_max : decay_rate;
      if (start_delay == '0) begin
        dly_q <= '0;
      end else if (start_delay < DLY_MIN) begin
        dly_q <= DLY_MIN;
      end else if (start_delay > DLY_MAX) begin
        dly_q <= DLY_MAX;
      end else begin
        dly_q <= start_delay;
      end
      if (reset_below_threshold < subrange_lo) begin
        thr_q <= subrange_lo;
      end else if (reset_below_threshold > subrange_hi) begin
        thr_q <= subrange_hi;
      end else begin
        thr_q <= reset_below_threshold;
      end
    end
  end

  // ------------------------------------------------------------
  // auto mode: max per hot object
  // ------------------------------------------------------------
  logic [TW-1:0] auto_max_q;
  logic          auto_vld_q;
  logic          auto_armed_q;
  logic          auto_hot;

  assign auto_hot = sample_temp >= subrange_lo + AUTO_HYST;

  always_ff @(posedge mclk) begin
    if (clr) begin
      auto_max_q   <= '0;
      auto_vld_q   <= 1'b0;
      auto_armed_q <= 1'b1;
    end else if (take && mode_q == PPK_MODE_AUTO) begin
      if (!auto_hot) begin
        auto_armed_q <= 1'b1;
      end else if (auto_armed_q || !auto_vld_q) begin
        auto_max_q   <= sample_temp;
        auto_vld_q   <= 1'b1;
        auto_armed_q <= 1'b0;
      end else if (sample_temp > auto_max_q) begin
        auto_max_q <= sample_temp;
      end
    end
  end

  // ------------------------------------------------------------
  // clear-time mode: collecting and showing buffers
  // ------------------------------------------------------------
  logic [CW-1:0] clr_cnt_q;
  logic [TW-1:0] buf_coll_q;
  logic          coll_any_q;
  logic [TW-1:0] buf_show_q;
  logic          show_vld_q;
  logic          clr_end;
  logic [TW-1:0] coll_nxt;
  logic          coll_any_nxt;
  logic          in_clear;

  assign in_clear = mode_q == PPK_MODE_CLEAR;
  assign clr_end  = in_clear && tick_ms && (clr_cnt_q + 1'b1 >= clr_len);

  always_comb begin
    coll_nxt     = buf_coll_q;
    coll_any_nxt = coll_any_q;
    if (take && (!coll_any_q || sample_temp > buf_coll_q)) begin
      coll_nxt     = sample_temp;
      coll_any_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr || !in_clear) begin
      clr_cnt_q <= '0;
    end else if (tick_ms) begin
      clr_cnt_q <= clr_end ? '0 : clr_cnt_q + 1'b1;
    end
  end

  // the collected max moves over at the interval end, the collector restarts
  always_ff @(posedge mclk) begin
    if (clr) begin
      buf_coll_q <= '0;
      coll_any_q <= 1'b0;
      buf_show_q <= '0;
      show_vld_q <= 1'b0;
    end else if (in_clear) begin
      if (clr_end) begin
        buf_show_q <= coll_nxt;
        show_vld_q <= coll_any_nxt;
        buf_coll_q <= '0;
        coll_any_q <= 1'b0;
      end else begin
        buf_coll_q <= coll_nxt;
        coll_any_q <= coll_any_nxt;
      end
    end
  end

  // ------------------------------------------------------------
  // smart mode: delay, hold and decay
  // ------------------------------------------------------------
  ppk_sm_t       sm_q;
  logic [13:0]   dly_cnt_q;
  logic [TW-1:0] peak_q;
  logic [TW-1:0] last_q;
  logic [AW-1:0] dec_acc_q;
  logic [AW-1:0] acc_sum;
  logic          dec_step;
  logic [TW-1:0] peak_dec;
  logic [TW-1:0] peak_nxt;
  logic [13:0]   dly_ms;
  logic          in_smart;
  logic          above;

  assign in_smart = mode_q == PPK_MODE_SMART;
  assign above    = sample_temp > thr_q;
  assign dly_ms   = 14'(dly_q) * 14'(MS_PER_DLY);
  assign acc_sum  = dec_acc_q + AW'(dec_q);
  // a zero rate never reaches a step, so the peak stays put
  assign dec_step = tick_fast && (acc_sum >= DECAY_STEP);

  always_comb begin
    peak_dec = peak_q;
    if (dec_step && peak_q != '0) begin
      peak_dec = peak_q - 1'b1;
    end
    if (peak_dec < last_q) begin
      peak_dec = last_q;
    end
    peak_nxt = peak_dec;
    if (take && sample_temp >= peak_dec) begin
      peak_nxt = sample_temp;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr || sm_q != PPK_SM_HOLD) begin
      dec_acc_q <= '0;
    end else if (tick_fast) begin
      dec_acc_q <= dec_step ? acc_sum - DECAY_STEP : acc_sum;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      last_q <= '0;
    end else if (take) begin
      last_q <= sample_temp;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr || !in_smart) begin
      sm_q      <= PPK_SM_IDLE;
      dly_cnt_q <= '0;
      peak_q    <= '0;
    end else begin
      unique case (sm_q)
        PPK_SM_IDLE: begin
          if (take && above) begin
            peak_q <= sample_temp;
            if (dly_q == '0) begin
              sm_q <= PPK_SM_HOLD;
            end else begin
              sm_q      <= PPK_SM_DELAY;
              dly_cnt_q <= '0;
            end
          end
        end
        PPK_SM_DELAY: begin
          if (take && !above) begin
            sm_q <= PPK_SM_IDLE;
          end else if (tick_ms) begin
            if (dly_cnt_q + 1'b1 >= dly_ms) begin
              sm_q   <= PPK_SM_HOLD;
              peak_q <= take ? sample_temp : last_q;
            end else begin
              dly_cnt_q <= dly_cnt_q + 1'b1;
            end
          end
        end
        PPK_SM_HOLD: begin
          if (take && !above) begin
            sm_q   <= PPK_SM_IDLE;
            peak_q <= '0;
          end else begin
            peak_q <= peak_nxt;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // output selection and buffering
  // ------------------------------------------------------------
  logic [TW-1:0] out_val;

  always_comb begin
    out_val = sample_temp;
    unique case (mode_q)
      PPK_MODE_OFF: begin
        out_val = sample_temp;
      end
      PPK_MODE_AUTO: begin
        out_val = (!auto_vld_q || (auto_hot && (auto_armed_q || sample_temp > auto_max_q))) ?
                  sample_temp : auto_max_q;
      end
      PPK_MODE_CLEAR: begin
        out_val = show_vld_q ? buf_show_q : sample_temp;
      end
      PPK_MODE_SMART: begin
        if (sm_q == PPK_SM_HOLD && above) begin
          out_val = peak_nxt;
        end else begin
          out_val = sample_temp;
        end
      end
    endcase
  end

  // mode changes drop the sample of that cycle's decision into momentary output
  ppk_fifo #(
    .W(TW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (fifo_ready),
    .in_data   (mode_chg ? sample_temp : out_val),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_temp)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      held_peak   <= '0;
      hold_active <= 1'b0;
    end else begin
      held_peak   <= in_smart ? peak_q : (in_clear ? buf_show_q : auto_max_q);
      hold_active <= (in_smart && sm_q == PPK_SM_HOLD) || (in_clear && show_vld_q) ||
                     (mode_q == PPK_MODE_AUTO && auto_vld_q);
    end
  end
endmodule

// file: verilog/ppk_pkg.sv
// constants, types and timing for the pyrometer peak picker
// How it works
// - one mode selector value, so only one peak mode is ever active
// - mode off passes every momentary sample straight through
// - clear interval is clamped to the range 10 ms to 25 s
// - clear mode collects a running maximum, restarted each interval
// - finished buffer maximum is shown steady for the whole next interval
// - peaks shorter than five response times may read attenuated
// - smart mode holds the highest recent temperature as output
// - smart settings are latched only while smart mode is selected
// - decay rate clamped to 166.66 C/s or 300 F/s by unit
// - decay rate zero means the held peak never decays
// - held peak falls at most at decay rate, never below momentary value
// - start delay is clamped to 0.02 s to 10.00 s
// - delay setting zero starts peaking right at target detection
// - leading edge of a target starts the delay, holding follows expiry
// - reset-below threshold is clamped into the configured sub-range
// - at or below the threshold output is momentary, no holding
package ppk_pkg;
  localparam int          TW            = 18;    // temperature, lsb 0.1 degree
  localparam int          RW            = 15;    // decay rate, lsb 0.01 deg/s
  localparam int          CW            = 15;    // clear interval in ms
  localparam int          DW            = 10;    // start delay, lsb 10 ms
  localparam int          AW            = 18;    // decay accumulator
  localparam int          FIFO_DEPTH    = 8;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          TICK_NS       = 100_000;
  // divide first: the plain product would not fit in 32 bits
  localparam int          TICK_CYC      = CLK_HZ / 1_000_000 * TICK_NS / 1000;
  localparam int          TICKS_PER_MS  = 10;
  localparam logic [CW-1:0] CLR_MIN_MS  = 15'h000A;
  localparam logic [CW-1:0] CLR_MAX_MS  = 15'h61A8;  // 25000 ms
  localparam logic [DW-1:0] DLY_MIN     = 10'h002;
  localparam logic [DW-1:0] DLY_MAX     = 10'h3E8;   // 1000 x 10 ms
  localparam logic [3:0]    MS_PER_DLY  = 4'hA;
  localparam logic [RW-1:0] DECAY_MAX_C = 15'h411A;  // 16666
  localparam logic [RW-1:0] DECAY_MAX_F = 15'h7530;  // 30000
  // 0.1 degree expressed in (0.01 deg/s) x (100 us) units
  localparam logic [AW-1:0] DECAY_STEP  = 18'h1_86A0;
  localparam logic [TW-1:0] AUTO_HYST   = 18'h0_000A;  // 1 degree

  typedef enum logic [1:0] {
    PPK_MODE_OFF   = 2'h0,
    PPK_MODE_AUTO  = 2'h1,
    PPK_MODE_CLEAR = 2'h2,
    PPK_MODE_SMART = 2'h3
  } ppk_mode_t;

  typedef enum logic [1:0] {
    PPK_SM_IDLE  = 2'h0,
    PPK_SM_DELAY = 2'h1,
    PPK_SM_HOLD  = 2'h3
  } ppk_sm_t;
endpackage

// file: verilog/ppk_timebase.sv
// prescaler making the 100 us and 1 ms enable pulses
`timescale 1ns/1ps
module ppk_timebase
  import ppk_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  output logic      tick_fast,
  output logic      tick_ms
);
  logic [15:0] pre_q;
  logic [3:0]  sub_q;

  assign tick_fast = pre_q == 16'(TICK - 1);
  assign tick_ms   = tick_fast && (sub_q == 4'(TICKS_PER_MS - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= '0;
      sub_q <= '0;
    end else begin
      pre_q <= tick_fast ? '0 : pre_q + 1'b1;
      if (tick_fast) begin
        sub_q <= tick_ms ? '0 : sub_q + 1'b1;
      end
    end
  end
endmodule
